// >>> shared/edm_pkg.sv
// edm_pkg: register map, field positions, reset values, modes and carriers
// for the external data-memory interface.
// assumes a byte-wide register port and a 40 MHz system clock.
package edm_pkg;
  // register offsets on the register port
  localparam logic [7:0] EDM_PAGE_OFF = 8'hAA;
  localparam logic [7:0] EDM_CFG_OFF = 8'hAB;
  localparam logic [7:0] EDM_MUX_OFF = 8'hAC;
  localparam logic [7:0] EDM_TIMING_OFF = 8'hAF;
  // reset values
  localparam logic [4:0] EDM_PAGE_RST = 5'h00;
  localparam logic [3:0] EDM_CFG_RST = 4'h3;
  localparam logic EDM_MUX_RST = 1'b0;
  localparam logic [7:0] EDM_TIMING_RST = 8'hFF;
  // field positions
  localparam int EDM_PAGE_MSB = 4;
  localparam int EDM_MODE_POS = 2;
  localparam int EDM_ALE_POS = 0;
  localparam int EDM_SETUP_POS = 6;
  localparam int EDM_STROBE_POS = 2;
  localparam int EDM_HOLD_POS = 0;
  // fixed cycles of every off-chip access beyond the programmed ones
  localparam logic [5:0] EDM_BASE_CYCLES = 6'h04;
  // first off-chip address in split modes, also the on-chip ram size
  localparam int EDM_BOUNDARY = 4096;
  typedef enum logic [1:0] {
    EDM_MODE_INT = 2'h0,
    EDM_MODE_SPLIT = 2'h1,
    EDM_MODE_BANK = 2'h2,
    EDM_MODE_EXT = 2'h3
  } edm_mode_t;
  // one external-move request from the cpu
  typedef struct packed {
    logic wr;
    logic wide;
    logic [15:0] data_pointer;
    logic [7:0] rptr;
    logic [7:0] wdata;
  } edm_req_t;
  // register port strobes with address and data
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } edm_bus_t;
endpackage

// >>> design/edm_xmem.sv
// edm_xmem: decodes external-move accesses into on-chip ram or timed
// off-chip cycles, with the page, config, mux and timing registers.
// assumes the cpu holds off new requests while busy_out is high.
//
// What this block does
// - mode 00 sends every access to on-chip ram, no off-chip cycle.
// - internal-only addresses wrap modulo the on-chip ram size.
// - 8-bit form: address high byte from page register, low from r0/.
// - 16-bit form: the full data pointer is the address.
// - split modes: below boundary on-chip, at or above off-chip.
// - split without bank: 8-bit off-chip leaves a[11:8] undriven, a[7:0] driven.
// - split modes: 16-bit decides by data pointer, drives all twelve lines.
// - bank mode: 8-bit off-chip drives a[11:8] from page, a[7:0] from r0/.
// - split modes: 8-bit goes off-chip when page field msb is one.
// - mode 11: every access off-chip, on-chip ram invisible.
// - external-only 8-bit ignores page, leaves a[11:8] undriven.
// - setup, hold, strobe and latch widths programmable in clocks.
// - non-muxed off-chip access takes programmed sum plus four clocks.
// - muxed access adds both latch phases, at least two clocks.
// - setup and hold settings reset to their maximum.
// - page register bits 7:5 read zero, whole register resets zero.
// - latch high and low phases each last field plus one clocks.
// - setup field inserts that many clocks before the strobe.
// - strobe lasts strobe field plus one clocks.
// - hold field keeps address that many clocks after the release clock.
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module edm_xmem #(
  parameter int BOUNDARY = edm_pkg::EDM_BOUNDARY
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire edm_pkg::edm_bus_t bus_in,
  output logic [7:0] reg_rdata_out,
  input wire logic req_in,
  input wire edm_pkg::edm_req_t req_data_in,
  output logic busy_out,
  output logic done_out,
  output logic [7:0] cpu_rdata_out,
  output logic [7:0] addr_lo_out,
  output logic addr_lo_oe_out,
  output logic [3:0] addr_hi_out,
  output logic addr_hi_oe_out,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe_out,
  output logic ale_out,
  output logic rd_n_out,
  output logic wr_n_out
);
  import edm_pkg::*;
  typedef enum {S_IDLE, S_INT, S_ADDR, S_ALE_HI, S_ALE_LO, S_SETUP, S_STROBE, S_RELEASE, S_HOLD, S_END} edm_state_t;
  // latched description of the access in flight
  typedef struct packed {
    logic wr;
    logic off;
    logic wide;
    logic hi_oe;
    logic [15:0] ea;
    logic [7:0] wdata;
    logic mux;
    logic [1:0] ale;
    logic [1:0] setup;
    logic [3:0] strobe;
    logic [1:0] hold;
  } edm_acc_t;
  logic [4:0] page;
  logic [3:0] cfg;
  logic mux_en;
  logic [7:0] timing;
  logic [7:0] xram [BOUNDARY];
  edm_state_t state, next_state;
  logic [3:0] cnt, next_cnt;
  edm_acc_t acc, next_acc;
  edm_mode_t mode;
  logic take;
  logic [15:0] new_ea;
  logic new_off;
  logic new_hi_oe;
  logic active;
  // on-chip index wraps modulo the populated ram
  function automatic logic [11:0] int_index(input logic [15:0] ea);
    int_index = 12'(32'(ea) % BOUNDARY);
  endfunction
  assign mode = edm_mode_t'(cfg[EDM_MODE_POS +: 2]);
  assign take = req_in && (state == S_IDLE);
  // effective address and routing decision for a new request
  always_comb begin
    if (req_data_in.wide) begin
      new_ea = req_data_in.data_pointer;
    end else begin
      new_ea = {3'h0, page, req_data_in.rptr};
    end
    unique case (mode)
      EDM_MODE_INT: new_off = 1'b0;
      EDM_MODE_EXT: new_off = 1'b1;
      default: begin
        if (req_data_in.wide) begin
          new_off = (32'(req_data_in.data_pointer) >= BOUNDARY);
        end else begin
          new_off = page[EDM_PAGE_MSB];
        end
      end
    endcase
    // upper lines only for 16-bit or bank select
    new_hi_oe = req_data_in.wide || (mode == EDM_MODE_BANK);
  end
  // snapshot of request and timing so register writes cannot bend a cycle
  always_comb begin
    next_acc = acc;
    if (take) begin
      next_acc.wr = req_data_in.wr;
      next_acc.off = new_off;
      next_acc.wide = req_data_in.wide;
      next_acc.hi_oe = new_hi_oe;
      next_acc.ea = new_ea;
      next_acc.wdata = req_data_in.wdata;
      next_acc.mux = mux_en;
      next_acc.ale = cfg[EDM_ALE_POS +: 2];
      next_acc.setup = timing[EDM_SETUP_POS +: 2];
      next_acc.strobe = timing[EDM_STROBE_POS +: 4];
      next_acc.hold = timing[EDM_HOLD_POS +: 2];
    end
  end
  // sequencer: each timed state lasts cnt+1 cycles
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    unique case (state)
      S_IDLE: begin
        if (take) begin
          next_state = new_off ? S_ADDR : S_INT;
        end
      end
      S_INT: next_state = S_END;
      S_ADDR: begin
        if (acc.mux) begin
          next_state = S_ALE_HI;
          next_cnt = {2'h0, acc.ale};
        end else if (acc.setup != 2'h0) begin
          next_state = S_SETUP;
          next_cnt = {2'h0, acc.setup - 2'h1};
        end else begin
          next_state = S_STROBE;
          next_cnt = acc.strobe;
        end
      end
      S_ALE_HI: begin
        if (cnt != 4'h0) begin
          next_cnt = cnt - 4'h1;
        end else begin
          next_state = S_ALE_LO;
          next_cnt = {2'h0, acc.ale};
        end
      end
      S_ALE_LO, S_SETUP: begin
        if (cnt != 4'h0) begin
          next_cnt = cnt - 4'h1;
        end else if (state == S_ALE_LO && acc.setup != 2'h0) begin
          next_state = S_SETUP;
          next_cnt = {2'h0, acc.setup - 2'h1};
        end else begin
          next_state = S_STROBE;
          next_cnt = acc.strobe;
        end
      end
      S_STROBE: begin
        if (cnt != 4'h0) begin
          next_cnt = cnt - 4'h1;
        end else begin
          next_state = S_RELEASE;
        end
      end
      S_RELEASE: begin
        if (acc.hold != 2'h0) begin
          next_state = S_HOLD;
          next_cnt = {2'h0, acc.hold - 2'h1};
        end else begin
          next_state = S_END;
        end
      end
      S_HOLD: begin
        if (cnt != 4'h0) begin
          next_cnt = cnt - 4'h1;
        end else begin
          next_state = S_END;
        end
      end
      S_END: next_state = S_IDLE;
    endcase
  end
  // state, counter and access snapshot
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      state <= S_IDLE;
      cnt <= 4'h0;
      acc <= '0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      acc <= next_acc;
    end
  end
  // register writes; page keeps only its five live bits
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      page <= EDM_PAGE_RST;
      cfg <= EDM_CFG_RST;
      mux_en <= EDM_MUX_RST;
      timing <= EDM_TIMING_RST;
    end else if (bus_in.wr) begin
      unique case (bus_in.addr)
        EDM_PAGE_OFF: page <= bus_in.wdata[4:0];
        EDM_CFG_OFF: cfg <= bus_in.wdata[3:0];
        EDM_MUX_OFF: mux_en <= bus_in.wdata[0];
        EDM_TIMING_OFF: timing <= bus_in.wdata;
        default: ;
      endcase
    end
  end
  // register reads, one cycle later; unmapped reads zero
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      reg_rdata_out <= 8'h00;
    end else if (bus_in.rd) begin
      unique case (bus_in.addr)
        EDM_PAGE_OFF: reg_rdata_out <= {3'h0, page};
        EDM_CFG_OFF: reg_rdata_out <= {4'h0, cfg};
        EDM_MUX_OFF: reg_rdata_out <= {7'h00, mux_en};
        EDM_TIMING_OFF: reg_rdata_out <= timing;
        default: reg_rdata_out <= 8'h00;
      endcase
    end else begin
      reg_rdata_out <= 8'h00;
    end
  end

  // on-chip ram: no reset, contents undefined until written
  always_ff @(posedge sys_clk_in) begin
    if (state == S_INT && acc.wr) begin
      xram[int_index(acc.ea)] <= acc.wdata;
    end
  end

  // read data toward the cpu: ram word or bus sampled at strobe end
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      cpu_rdata_out <= 8'h00;
    end else if (state == S_INT && !acc.wr) begin
      cpu_rdata_out <= xram[int_index(acc.ea)];
    end else if (state == S_STROBE && cnt == 4'h0 && !acc.wr) begin
      cpu_rdata_out <= data_in;
    end
  end

  assign active = (next_state != S_IDLE) && (next_state != S_INT) && (next_state != S_END);
  // pins are registered from the next state so they change with it
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      busy_out <= 1'b0;
      done_out <= 1'b0;
      addr_lo_out <= 8'h00;
      addr_lo_oe_out <= 1'b0;
      addr_hi_out <= 4'h0;
      addr_hi_oe_out <= 1'b0;
      data_out <= 8'h00;
      data_oe_out <= 1'b0;
      ale_out <= 1'b0;
      rd_n_out <= 1'b1;
      wr_n_out <= 1'b1;
    end else begin
      busy_out <= (next_state != S_IDLE) && (next_state != S_END);
      done_out <= (next_state == S_END);
      addr_lo_out <= next_acc.ea[7:0];
      addr_lo_oe_out <= active && !next_acc.mux;
      addr_hi_out <= next_acc.ea[11:8];
      addr_hi_oe_out <= active && next_acc.hi_oe;
      // muxed: address low rides the data lines while the latch is open
      data_out <= (next_state == S_ALE_HI) ? next_acc.ea[7:0] : next_acc.wdata;
      data_oe_out <= (next_state == S_ALE_HI) || (next_acc.wr && (next_state == S_SETUP ||
                     next_state == S_STROBE || next_state == S_RELEASE));
      ale_out <= (next_state == S_ALE_HI);
      rd_n_out <= !(next_state == S_STROBE && !next_acc.wr);
      wr_n_out <= !(next_state == S_STROBE && next_acc.wr);
    end
  end
  // helper counters for the timing checks below
  logic [5:0] cyc;
  logic [5:0] exp_total;
  logic [4:0] strb_cnt;
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      cyc <= 6'h00;
      strb_cnt <= 5'h00;
    end else begin
      cyc <= take ? 6'h02 : (state != S_IDLE ? cyc + 6'h01 : 6'h00); // take cycle already counted
      strb_cnt <= (!rd_n_out || !wr_n_out) ? strb_cnt + 5'h01 : 5'h00;
    end
  end
  assign exp_total = 6'(acc.setup) + 6'(acc.strobe) + 6'h01 + 6'(acc.hold) + EDM_BASE_CYCLES +
                     (acc.mux ? ((6'(acc.ale) + 6'h01) << 1) : 6'h00);
  a_internal_only: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (take && mode == EDM_MODE_INT) |=> (rd_n_out && wr_n_out && !addr_lo_oe_out && !data_oe_out) [*2])
    else $error("internal-only access started an off-chip strobe");
  a_ext_always_off: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (take && mode == EDM_MODE_EXT) |=> (state == S_ADDR) ##1 busy_out)
    else $error("external-only access did not go off-chip");
  a_split_wide_cut: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (take && req_data_in.wide && (mode == EDM_MODE_SPLIT || mode == EDM_MODE_BANK))
    |=> (acc.off == (32'(acc.ea) >= BOUNDARY)))
    else $error("split decision does not follow the boundary");
  a_page_msb_off: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (take && !req_data_in.wide && mode == EDM_MODE_SPLIT) |=> (acc.off == $past(page[4])))
    else $error("8-bit split routing ignores the page msb");
  a_hi_lines_drive: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    addr_hi_oe_out |-> (acc.wide || acc.ea[15:8] == {3'h0, page} && cfg[3:2] == 2'h2))
    else $error("upper address lines driven without cause");
  a_bank_hi_addr: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (addr_hi_oe_out && !acc.wide) |-> (addr_hi_out == acc.ea[11:8]) && addr_lo_out == acc.ea[7:0])
    else $error("bank address lines wrong");
  a_page_high_zero: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (bus_in.rd && bus_in.addr == EDM_PAGE_OFF) |=> (reg_rdata_out[7:5] == 3'h0))
    else $error("page register upper bits not zero");
  a_access_length: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (done_out && acc.off) |-> (cyc == exp_total))
    else $error("off-chip access length differs from programmed sum");
  a_strobe_width: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    ($past(!rd_n_out || !wr_n_out) && rd_n_out && wr_n_out) |-> (strb_cnt == 5'(acc.strobe) + 5'h01))
    else $error("strobe width differs from field plus one");
  a_timing_reset: assert property (@(posedge sys_clk_in)
    ($past(rst_in) && !rst_in) |-> (timing == EDM_TIMING_RST && page == EDM_PAGE_RST))
    else $error("reset values of timing or page wrong");
endmodule
`default_nettype wire

// >>> sim/edm_sram_model.sv
// edm_sram_model: behavioural byte ram on the far side of the interface.
// assumes undriven a[11:8] park low and a transparent latch for muxed a[7:0].
`timescale 1ns/1ps
`default_nettype none
module edm_sram_model (
  input wire logic clk_in,
  input wire logic [7:0] addr_lo_in,
  input wire logic addr_lo_oe_in,
  input wire logic [3:0] addr_hi_in,
  input wire logic addr_hi_oe_in,
  input wire logic [7:0] ad_in,
  input wire logic ale_in,
  input wire logic rd_n_in,
  input wire logic wr_n_in,
  output logic [7:0] data_out
);
  logic [7:0] mem [0:4095];
  logic [7:0] latched = 8'h00;
  logic [7:0] last = 8'h00;
  logic [11:0] a;
  // latch follows the shared bus while ale is high, writes land during the strobe
  always @(posedge clk_in) begin
    if (ale_in) begin
      latched <= ad_in;
    end
    if (!wr_n_in) begin
      mem[a] <= ad_in;
    end
    if (!rd_n_in) begin
      last <= mem[a];
    end
  end
  // released bus shows the inverse of the last byte so a late sample cannot pass
  assign a = {addr_hi_oe_in ? addr_hi_in : 4'h0, addr_lo_oe_in ? addr_lo_in : latched};
  assign data_out = !rd_n_in ? mem[a] : ~last;
endmodule
`default_nettype wire

// >>> sim/edm_xmem_tb_top.sv
// edm_xmem_tb_top: directed scenarios for the external data-memory interface.
// assumes the sram model on the far side and a 40 MHz system clock.
`timescale 1ns/1ps
`default_nettype none
module edm_xmem_tb_top;
  import edm_pkg::*;
  logic sys_clk_in = 1'b0;
  logic rst_in = 1'b1;
  edm_bus_t bus = '0;
  logic req = 1'b0;
  edm_req_t rq = '0;
  logic [7:0] reg_rdata, cpu_rdata, addr_lo, data_o, data_i;
  logic [3:0] addr_hi;
  logic busy, done, lo_oe, hi_oe, data_oe, ale, rd_n, wr_n;
  int errors = 0;
  int samples_checked = 0;
  int n_cyc, n_strb, n_ale, hi_seen, n_doe, n_busy;

  edm_xmem u_dut (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .bus_in(bus), .reg_rdata_out(reg_rdata),
    .req_in(req), .req_data_in(rq), .busy_out(busy), .done_out(done), .cpu_rdata_out(cpu_rdata),
    .addr_lo_out(addr_lo), .addr_lo_oe_out(lo_oe), .addr_hi_out(addr_hi), .addr_hi_oe_out(hi_oe),
    .data_in(data_i), .data_out(data_o), .data_oe_out(data_oe), .ale_out(ale), .rd_n_out(rd_n),
    .wr_n_out(wr_n));
  edm_sram_model u_ram (.clk_in(sys_clk_in), .addr_lo_in(addr_lo), .addr_lo_oe_in(lo_oe),
    .addr_hi_in(addr_hi), .addr_hi_oe_in(hi_oe), .ad_in(data_o), .ale_in(ale), .rd_n_in(rd_n),
    .wr_n_in(wr_n), .data_out(data_i));

  // 25 ns system clock
  initial begin
    forever #12.5 sys_clk_in = ~sys_clk_in;
  end

  task automatic test_done;
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // byte results: register and cpu read data
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge sys_clk_in);
    bus <= '0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rreg(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk_in);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge sys_clk_in);
    bus <= '0;
    #1;
    chk_byte(reg_rdata, e);
  endtask

  // one cpu access; counts cycles from the take cycle through the done cycle, plus strobe, ale, drive, busy
  task automatic acc(input logic w, input logic wd, input logic [15:0] dp, input logic [7:0] rp,
                     input logic [7:0] wv);
    int k;
    n_cyc = 2;
    n_strb = 0;
    n_ale = 0;
    n_doe = 0;
    n_busy = 0;
    hi_seen = 0;
    @(posedge sys_clk_in);
    req <= 1'b1;
    rq <= '{w, wd, dp, rp, wv};
    @(posedge sys_clk_in);
    req <= 1'b0;
    for (k = 0; k < 100 && done !== 1'b1; k++) begin
      @(posedge sys_clk_in);
      #1;
      n_cyc++;
      n_strb += int'(rd_n === 1'b0 || wr_n === 1'b0);
      n_doe += int'(data_oe === 1'b1);
      n_busy += int'(busy === 1'b1);
      n_ale += int'(ale === 1'b1);
      if (hi_oe === 1'b1) begin
        hi_seen = 16 + int'(addr_hi);
      end
    end
    if (k >= 100) begin
      errors++;
      test_done();
    end
  endtask

  task automatic t_regs;
    rreg(EDM_PAGE_OFF, 8'h00);
    rreg(EDM_CFG_OFF, 8'h03);
    rreg(EDM_TIMING_OFF, 8'hFF);
    rreg(EDM_MUX_OFF, 8'h00);
    rreg(8'hA0, 8'h00);
    wreg(EDM_PAGE_OFF, 8'hFF);
    rreg(EDM_PAGE_OFF, 8'h1F);
  endtask

  // internal-only mode at reset: no strobes, addresses wrap
  task automatic t_internal;
    acc(1'b1, 1'b1, 16'h0007, 8'h00, 8'h3C);
    chk(16'(n_strb), 16'h0000);
    acc(1'b0, 1'b1, 16'h1007, 8'h00, 8'h00);
    chk_byte(cpu_rdata, 8'h3C);
    wreg(EDM_PAGE_OFF, 8'h10);
    acc(1'b0, 1'b0, 16'h0000, 8'h07, 8'h00);
    chk_byte(cpu_rdata, 8'h3C);
  endtask

  // external-only, first access still on the reset timing
  task automatic t_external;
    wreg(EDM_CFG_OFF, 8'h0F);
    acc(1'b1, 1'b1, 16'h0010, 8'h00, 8'hA5);
    chk(16'(n_cyc), 16'd26);
    chk(16'(n_strb), 16'd16);
    chk(16'(hi_seen), 16'd16);
    chk(16'(n_doe), 16'd20);
    chk(16'(n_busy), 16'd23);
    wreg(EDM_TIMING_OFF, 8'h00);
    acc(1'b0, 1'b0, 16'h0000, 8'h10, 8'h00);
    chk_byte(cpu_rdata, 8'hA5);
    chk(16'(n_cyc), 16'd5);
    chk(16'(hi_seen), 16'd0);
    wreg(EDM_TIMING_OFF, 8'h49);
    acc(1'b0, 1'b1, 16'h0010, 8'h00, 8'h00);
    chk(16'(n_cyc), 16'd9);
    chk(16'(n_strb), 16'd3);
  endtask

  // muxed bus: ale phases add to the access
  task automatic t_mux;
    wreg(EDM_TIMING_OFF, 8'h00);
    wreg(EDM_MUX_OFF, 8'h01);
    wreg(EDM_CFG_OFF, 8'h0C);
    acc(1'b0, 1'b1, 16'h0010, 8'h00, 8'h00);
    chk(16'(n_cyc), 16'd7);
    chk(16'(n_ale), 16'd1);
    chk_byte(cpu_rdata, 8'hA5);
    wreg(EDM_CFG_OFF, 8'h0D);
    acc(1'b0, 1'b1, 16'h0010, 8'h00, 8'h00);
    chk(16'(n_cyc), 16'd9);
    chk(16'(n_ale), 16'd2);
    wreg(EDM_MUX_OFF, 8'h00);
  endtask

  // split modes: boundary, page msb and upper address drive
  task automatic t_split;
    wreg(EDM_CFG_OFF, 8'h04);
    acc(1'b1, 1'b1, 16'h0FFF, 8'h00, 8'h11);
    chk(16'(n_strb), 16'd0);
    acc(1'b1, 1'b1, 16'h1000, 8'h00, 8'h22);
    chk(16'(n_strb), 16'd1);
    chk(16'(hi_seen), 16'd16);
    wreg(EDM_PAGE_OFF, 8'h12);
    acc(1'b0, 1'b0, 16'h0000, 8'h34, 8'h00);
    chk(16'(n_strb), 16'd1);
    chk(16'(hi_seen), 16'd0);
    wreg(EDM_CFG_OFF, 8'h08);
    acc(1'b0, 1'b0, 16'h0000, 8'h34, 8'h00);
    chk(16'(hi_seen), 16'd18);
    wreg(EDM_PAGE_OFF, 8'h02);
    acc(1'b0, 1'b0, 16'h0000, 8'h34, 8'h00);
    chk(16'(n_strb), 16'd0);
    acc(1'b0, 1'b1, 16'h0FFF, 8'h00, 8'h00);
    chk_byte(cpu_rdata, 8'h11);
  endtask

  // main sequence
  initial begin
    repeat (16) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    t_regs();
    t_internal();
    t_external();
    t_mux();
    t_split();
    test_done();
  end
endmodule
`default_nettype wire
